// ===== core/pclk_divider.sv
// Divides the core clock by two to make the pixel clock sent to the device.
// Assumes the sync, data-valid and pixel outputs it feeds are updated on the tick it raises.
`default_nettype none

module pclk_divider (
    input wire logic core_clk,
    input wire logic rst,
    pclk_link_if.gen link
);
    import video_src_pkg::*;

    typedef struct packed {
        logic pclk;
    } div_state_type;

    div_state_type cur_q;
    div_state_type nxt_d;

    // ==========================================================
    // Divider
    // ==========================================================
    always_comb begin
        nxt_d = cur_q;
        nxt_d.pclk = ~cur_q.pclk;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cur_q <= '0;
        end else begin
            cur_q <= nxt_d;
        end
    end

    // The tick marks the edge on which the pixel clock falls, so every pin driven
    // on it is settled a full core period before the device samples on the rise.
    assign link.pclk = cur_q.pclk;
    assign link.tick = cur_q.pclk;
endmodule

`default_nettype wire

// ===== core/pclk_link_if.sv
// Interface carrying the divided pixel clock and its update tick between the source modules.
// Assumes both ends run on the core clock.
`default_nettype none

interface pclk_link_if;
    logic pclk;
    logic tick;

    modport gen (
        output pclk,
        output tick
    );

    modport use_side (
        input pclk,
        input tick
    );
endinterface

`default_nettype wire

// ===== core/video_source.sv
// Video source: drives the device's pixel clock, syncs, data-valid, pixel data,
// eye select and active-low reset from the core clock.
// Assumes pixel_in and the control inputs come from logic on core_clk.
`default_nettype none

module video_source #(
    parameter int EYE_SETUP_CYC = video_src_pkg::EYE_SETUP_CYCLES,
    parameter int EYE_HOLD_CYC = video_src_pkg::EYE_HOLD_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic stereo_en,
    input wire logic reset_req,
    input wire logic [video_src_pkg::PIX_W-1:0] pixel_in,
    output logic pixel_take,
    output logic frame_done,
    output logic pclk_out,
    output logic frame_sync,
    output logic line_sync,
    output logic pixel_valid_in,
    output logic [video_src_pkg::PIX_W-1:0] pixel_bus,
    output logic eye_select,
    output logic reset_n_in
);
    import video_src_pkg::*;

    localparam logic [TIMER_W-1:0] RESET_LOAD = TIMER_W'(RESET_LOW_CYCLES - 1);
    localparam logic [TIMER_W-1:0] SETUP_LOAD = TIMER_W'(EYE_SETUP_CYC);
    localparam logic [TIMER_W-1:0] HOLD_LOAD = TIMER_W'(EYE_HOLD_CYC);

    typedef struct packed {
        frame_state_type state;
        line_phase_type phase;
        logic [HCNT_W-1:0] hcnt;
        logic [LINE_W-1:0] line;
        logic [TIMER_W-1:0] tmr;
        logic [TIMER_W-1:0] hold;
        logic eye_changed;
        logic vsync;
        logic hsync;
        logic valid;
        logic [PIX_W-1:0] pixel;
        logic eye;
        logic reset_n;
        logic take;
        logic done;
    } src_state_type;

    localparam src_state_type RESET_STATE = '{
        state: ST_RESET,
        phase: H_SYNC,
        hcnt: '0,
        line: '0,
        tmr: RESET_LOAD,
        hold: '0,
        eye_changed: 1'b0,
        vsync: ~SYNC_ACTIVE,
        hsync: ~SYNC_ACTIVE,
        valid: 1'b0,
        pixel: '0,
        eye: 1'b0,
        reset_n: 1'b0,
        take: 1'b0,
        done: 1'b0
    };

    src_state_type cur_q;
    src_state_type nxt_d;
    pclk_link_if link ();

    pclk_divider u_div (
        .core_clk(core_clk),
        .rst(rst),
        .link(link)
    );

    logic act_line;
    logic phase_end;
    logic [HCNT_W-1:0] phase_len;

    // ==========================================================
    // Line decode
    // ==========================================================
    always_comb begin
        act_line = (cur_q.line >= ACT_FIRST_LINE) && (cur_q.line < ACT_END_LINE);
        case (cur_q.phase)
            H_SYNC: phase_len = HSYNC_PCLKS;
            H_BP: phase_len = HBP_PCLKS;
            H_ACT: phase_len = HACT_PCLKS;
            H_FP: phase_len = HFP_PCLKS;
            default: phase_len = HSYNC_PCLKS;
        endcase
        phase_end = (cur_q.hcnt == phase_len - 8'h01);
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        nxt_d = cur_q;
        nxt_d.take = 1'b0;
        nxt_d.done = 1'b0;
        if (cur_q.hold != '0) begin
            nxt_d.hold = cur_q.hold - 20'h00001;
        end
        case (cur_q.state)
            ST_RESET: begin
                // The device reset is held low for the whole count, then released.
                nxt_d.reset_n = 1'b0;
                if (cur_q.tmr == '0) begin
                    nxt_d.reset_n = 1'b1;
                    nxt_d.state = ST_GAP;
                    nxt_d.eye_changed = 1'b0;
                end else begin
                    nxt_d.tmr = cur_q.tmr - 20'h00001;
                end
            end
            ST_GAP: begin
                if (cur_q.tmr != '0) begin
                    nxt_d.tmr = cur_q.tmr - 20'h00001;
                end
                // In stereo the eye flips only once the hold after the last frame sync
                // edge has run out, and the next frame waits out the setup time.
                if (stereo_en && !cur_q.eye_changed && cur_q.hold == '0) begin
                    nxt_d.eye = ~cur_q.eye;
                    nxt_d.tmr = SETUP_LOAD;
                    nxt_d.eye_changed = 1'b1;
                end else if (run && link.tick && cur_q.tmr == '0 &&
                             (cur_q.eye_changed || !stereo_en)) begin
                    // The frame sync edge and the first line sync edge coincide here.
                    nxt_d.state = ST_FRAME;
                    nxt_d.eye_changed = 1'b0;
                    nxt_d.phase = H_SYNC;
                    nxt_d.hcnt = '0;
                    nxt_d.line = '0;
                    nxt_d.vsync = SYNC_ACTIVE;
                    nxt_d.hsync = SYNC_ACTIVE;
                end
            end
            ST_FRAME: begin
                if (link.tick) begin
                    nxt_d.hcnt = cur_q.hcnt + 8'h01;
                    if (phase_end) begin
                        nxt_d.hcnt = '0;
                    end
                    case (cur_q.phase)
                        H_SYNC: begin
                            if (phase_end) begin
                                nxt_d.hsync = ~SYNC_ACTIVE;
                                nxt_d.phase = H_BP;
                            end
                        end
                        H_BP: begin
                            if (phase_end) begin
                                // Data-valid rises only after the full back porch.
                                nxt_d.phase = H_ACT;
                                if (act_line) begin
                                    nxt_d.valid = 1'b1;
                                    nxt_d.pixel = pixel_in;
                                    nxt_d.take = 1'b1;
                                end
                            end
                        end
                        H_ACT: begin
                            if (phase_end) begin
                                nxt_d.valid = 1'b0;
                                nxt_d.pixel = '0;
                                nxt_d.phase = H_FP;
                            end else if (act_line) begin
                                nxt_d.pixel = pixel_in;
                                nxt_d.take = 1'b1;
                            end
                        end
                        H_FP: begin
                            if (phase_end) begin
                                // The front porch has run its full length before the next edge.
                                if (cur_q.line == LAST_LINE) begin
                                    // The last lines are the vertical front porch; the gap
                                    // only lengthens it.
                                    nxt_d.state = ST_GAP;
                                    nxt_d.done = 1'b1;
                                    nxt_d.tmr = '0;
                                end else begin
                                    nxt_d.line = cur_q.line + 8'h01;
                                    nxt_d.phase = H_SYNC;
                                    nxt_d.hsync = SYNC_ACTIVE;
                                    // Frame sync drops at the line sync that ends its line.
                                    if (cur_q.line + 8'h01 == VSYNC_END_LINE) begin
                                        nxt_d.vsync = ~SYNC_ACTIVE;
                                        nxt_d.hold = HOLD_LOAD;
                                    end
                                end
                            end
                        end
                        default: begin
                            nxt_d.phase = H_SYNC;
                        end
                    endcase
                end
            end
            default: begin
                nxt_d = RESET_STATE;
            end
        endcase
        // A reset request starts a fresh device reset pulse from any state.
        if (reset_req) begin
            nxt_d = RESET_STATE;
            nxt_d.eye = cur_q.eye;
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cur_q <= RESET_STATE;
        end else begin
            cur_q <= nxt_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign pixel_take = cur_q.take;
    assign frame_done = cur_q.done;
    assign pclk_out = link.pclk;
    assign frame_sync = cur_q.vsync;
    assign line_sync = cur_q.hsync;
    assign pixel_valid_in = cur_q.valid;
    assign pixel_bus = cur_q.pixel;
    assign eye_select = cur_q.eye;
    assign reset_n_in = cur_q.reset_n;
endmodule

`default_nettype wire

// ===== core/video_src_pkg.sv
// Constants for the parallel video source that drives a display controller's pixel port.
// Assumes one 100 MHz core clock with a synchronous active-high reset; no software registers.
`default_nettype none

package video_src_pkg;

    // ==========================================================
    // Clock
    // ==========================================================
    localparam int CORE_CLK_MHZ = 100;
    localparam int CORE_PERIOD_NS = 10;

    // ==========================================================
    // Device reset pulse
    // ==========================================================
    // The least low time is 1.25 us, held here in nanoseconds and rounded up to cycles.
    localparam int RESET_LOW_NS = 1250;
    localparam int RESET_LOW_CYCLES = (RESET_LOW_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

    // ==========================================================
    // Eye select setup and hold around frame sync
    // ==========================================================
    localparam int EYE_SETUP_US = 1000;
    localparam int EYE_HOLD_US = 1000;
    localparam int EYE_SETUP_CYCLES = EYE_SETUP_US * CORE_CLK_MHZ;
    localparam int EYE_HOLD_CYCLES = EYE_HOLD_US * CORE_CLK_MHZ;
    localparam int TIMER_W = 20;

    // ==========================================================
    // Horizontal timing in pixel clocks
    // ==========================================================
    localparam int HCNT_W = 8;
    localparam logic [HCNT_W-1:0] HSYNC_PCLKS = 8'h08;
    localparam logic [HCNT_W-1:0] HSYNC_MIN_PCLKS = 8'h04;
    localparam logic [HCNT_W-1:0] HSYNC_MAX_PCLKS = 8'h80;
    localparam logic [HCNT_W-1:0] HBP_PCLKS = 8'h04;
    localparam logic [HCNT_W-1:0] HACT_PCLKS = 8'h20;
    localparam logic [HCNT_W-1:0] HFP_PCLKS = 8'h08;

    // ==========================================================
    // Vertical timing in lines
    // ==========================================================
    localparam int LINE_W = 8;
    localparam int SRC_ACTIVE_LINES = 8;
    localparam int MIRROR_USED_LINES = 8;
    localparam int LINE_RATIO_CEIL =
        (SRC_ACTIVE_LINES + MIRROR_USED_LINES - 1) / MIRROR_USED_LINES;
    localparam int LINE_RATIO = (LINE_RATIO_CEIL > 1) ? LINE_RATIO_CEIL : 1;
    localparam int BLANK_MIN_LINES = 6 + 8 * LINE_RATIO;
    localparam int VSYNC_LINES = 1;
    localparam int VBP_MIN_LINES = 2;
    localparam int VFP_MIN_LINES = 1;
    localparam int VBP_LINES = 4;
    localparam int VFP_LINES = (BLANK_MIN_LINES - VBP_LINES > VFP_MIN_LINES) ?
        (BLANK_MIN_LINES - VBP_LINES) : VFP_MIN_LINES;
    localparam int TOTAL_LINES = VBP_LINES + SRC_ACTIVE_LINES + VFP_LINES;
    localparam logic [LINE_W-1:0] VSYNC_END_LINE = 8'(VSYNC_LINES);
    localparam logic [LINE_W-1:0] ACT_FIRST_LINE = 8'(VBP_LINES);
    localparam logic [LINE_W-1:0] ACT_END_LINE = 8'(VBP_LINES + SRC_ACTIVE_LINES);
    localparam logic [LINE_W-1:0] LAST_LINE = 8'(TOTAL_LINES - 1);

    // ==========================================================
    // Pixel bus and sync polarity
    // ==========================================================
    localparam int PIX_W = 24;
    localparam logic SYNC_ACTIVE = 1'b1;

    // ==========================================================
    // State encodings
    // ==========================================================
    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_GAP = 3'b010,
        ST_FRAME = 3'b100
    } frame_state_type;

    typedef enum logic [3:0] {
        H_SYNC = 4'b0001,
        H_BP = 4'b0010,
        H_ACT = 4'b0100,
        H_FP = 4'b1000
    } line_phase_type;

endpackage

`default_nettype wire

// ===== dv/pixel_port_model.sv
// Behavioural model of the display controller's parallel pixel input.
// Assumes the pixel clock comes from the source; it drives nothing back.
`default_nettype none
module pixel_port_model (
    input wire logic pclk,
    input wire logic reset_n_in,
    input wire logic frame_sync,
    input wire logic line_sync,
    input wire logic pixel_valid_in,
    input wire logic [video_src_pkg::PIX_W-1:0] pixel_bus,
    input wire logic eye_select
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Capture and timing watch
    // ==========================================================
    logic [video_src_pkg::PIX_W-1:0] got[$];
    logic eyes[$];
    logic bad = 1'b0;
    logic ls_p = 1'b0;
    logic v_p = 1'b0;
    logic fs_p = 1'b0;
    int hw = 0;
    int bp = 0;
    int fp = 99;
    always @(posedge pclk or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bad = 1'b0;
            hw = 0;
            fp = 99;
            ls_p = 1'b0;
            v_p = 1'b0;
            fs_p = 1'b0;
        end else begin
            if (pixel_valid_in) got.push_back(pixel_bus);
            if (frame_sync && !fs_p) eyes.push_back(eye_select);
            if (line_sync && !ls_p && fp < 8) bad = 1'b1;
            if (!line_sync && ls_p && (hw < 4 || hw > 128)) bad = 1'b1;
            if (pixel_valid_in && !v_p && bp < 4) bad = 1'b1;
            hw = line_sync ? hw + 1 : 0;
            bp = (line_sync && !ls_p) ? 1 : bp + 1;
            fp = (!pixel_valid_in && v_p) ? 1 : fp + 1;
            ls_p = line_sync;
            v_p = pixel_valid_in;
            fs_p = frame_sync;
        end
    end
endmodule
`default_nettype wire

// ===== dv/video_source_assertions.sv
// Pin timing checker for the video source.
// Bound to video_source and sees its ports only.
`default_nettype none
module video_source_checker #(
    parameter int EYE_SETUP_CYC = 200,
    parameter int EYE_HOLD_CYC = 200
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic frame_sync,
    input wire logic line_sync,
    input wire logic pixel_valid_in,
    input wire logic eye_select,
    input wire logic reset_n_in
);
    import video_src_pkg::*;
    localparam int SAT = 1000000;
    localparam int LINE_CYC = 2 * (HSYNC_PCLKS + HBP_PCLKS + HACT_PCLKS + HFP_PCLKS);
    localparam int HBP_CYC = 2 * (HSYNC_PCLKS + HBP_PCLKS);
    int ls_age, vd_age, fs_age, ey_age, ln_q, act_q, rl_q;
    logic seen_q;
    // ==========================================================
    // Edge ages
    // ==========================================================
    // Ages restart saturated so that no edge from before a reset is ever measured.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ls_age <= SAT;
            vd_age <= SAT;
            fs_age <= SAT;
            ey_age <= SAT;
            ln_q <= 0;
            act_q <= 0;
            rl_q <= 0;
            seen_q <= 1'b0;
        end else begin
            ls_age <= $rose(line_sync) ? 1 : ls_age + 1;
            vd_age <= $fell(pixel_valid_in) ? 1 : vd_age + 1;
            fs_age <= $changed(frame_sync) ? 1 : fs_age + 1;
            ey_age <= $changed(eye_select) ? 1 : ey_age + 1;
            rl_q <= reset_n_in ? 0 : rl_q + 1;
            ln_q <= $rose(frame_sync) ? 0 : ln_q + int'($rose(line_sync));
            act_q <= $rose(frame_sync) ? 0 : act_q + int'($rose(pixel_valid_in));
            seen_q <= seen_q | $rose(frame_sync);
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // A whole previous frame is needed before blanking can be judged.
    sequence frame_rise_s;
        $rose(frame_sync) ##0 seen_q;
    endsequence
    vsync_width_a: assert property ($fell(frame_sync) |-> fs_age >= LINE_CYC)
        else $error("frame sync shorter than a line");
    vbp_lines_a: assert property ($rose(pixel_valid_in) |-> ln_q >= VBP_MIN_LINES)
        else $error("back porch too short");
    blank_total_a: assert property (frame_rise_s |-> ln_q + 1 - act_q >= BLANK_MIN_LINES)
        else $error("vertical blanking too short");
    hsync_width_a: assert property ($fell(line_sync) |-> ls_age == 2 * HSYNC_PCLKS)
        else $error("line sync width wrong");
    hbp_width_a: assert property ($rose(pixel_valid_in) |-> ls_age == HBP_CYC)
        else $error("horizontal back porch wrong");
    hfp_width_a: assert property ($rose(line_sync) |-> vd_age >= 2 * HFP_PCLKS)
        else $error("horizontal front porch too short");
    eye_setup_a: assert property ($changed(frame_sync) |-> ey_age >= EYE_SETUP_CYC)
        else $error("eye select setup too short");
    eye_hold_a: assert property ($changed(eye_select) |-> fs_age >= EYE_HOLD_CYC)
        else $error("eye select hold too short");
    reset_low_a: assert property ($rose(reset_n_in) |-> rl_q >= RESET_LOW_CYCLES)
        else $error("device reset pulse too short");
endmodule
`default_nettype wire

// ===== dv/video_source_tb_top.sv
// Bench for the video source with a behavioural pixel port on its pins.
// Assumes package, link interface, design, checker and port model compile first.
`default_nettype none
module video_source_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import video_src_pkg::*;
    localparam int EYE_CYC = 200;
    localparam int PIX_FRAME = HACT_PCLKS * SRC_ACTIVE_LINES;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic run = 1'b0;
    logic stereo_en = 1'b0;
    logic reset_req = 1'b0;
    logic [PIX_W-1:0] pixel_in = '0;
    logic [PIX_W-1:0] pixel_bus;
    logic [PIX_W-1:0] exp_q[$];
    logic pixel_take, frame_done, pclk_out, frame_sync, line_sync, pixel_valid_in;
    logic eye_select, reset_n_in, last_eye;
    int mismatches = 0;
    int checks_done = 0;
    int frames = 0;
    int n;
    video_source #(.EYE_SETUP_CYC(EYE_CYC), .EYE_HOLD_CYC(EYE_CYC)) DUT (
        .core_clk(core_clk), .rst(rst), .run(run), .stereo_en(stereo_en),
        .reset_req(reset_req), .pixel_in(pixel_in), .pixel_take(pixel_take),
        .frame_done(frame_done), .pclk_out(pclk_out), .frame_sync(frame_sync),
        .line_sync(line_sync), .pixel_valid_in(pixel_valid_in), .pixel_bus(pixel_bus),
        .eye_select(eye_select), .reset_n_in(reset_n_in)
    );
    pixel_port_model dev (
        .pclk(pclk_out), .reset_n_in(reset_n_in), .frame_sync(frame_sync),
        .line_sync(line_sync), .pixel_valid_in(pixel_valid_in), .pixel_bus(pixel_bus),
        .eye_select(eye_select)
    );
    // ==========================================================
    // Clock, stimulus and checks
    // ==========================================================
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // A new pixel is offered only once the one in flight is confirmed loaded.
    always @(posedge core_clk) begin
        #1;
        if (pixel_take === 1'b1) begin
            exp_q.push_back(pixel_in);
            pixel_in = PIX_W'($urandom);
        end
        if (frame_done === 1'b1) frames++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic finish_test();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cycles(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic check_frame(input bit st);
        int f0;
        f0 = frames;
        n = 0;
        while (frames == f0 && n < 6000) begin
            cycles(1);
            n++;
        end
        if (frames == f0) begin
            mismatches++;
            finish_test();
        end
        check(dev.got.size(), PIX_FRAME);
        check(exp_q.size(), PIX_FRAME);
        while (exp_q.size() > 0 && dev.got.size() > 0) begin
            check(32'(dev.got.pop_front()), 32'(exp_q.pop_front()));
        end
        check(32'(dev.bad), 32'h0);
        // The inverse is taken at one bit; a sized cast would widen before inverting.
        if (st) check(32'(dev.eyes[$]), {31'h0, ~last_eye});
        last_eye = dev.eyes[$];
        exp_q.delete();
        dev.got.delete();
    endtask
    initial begin
        void'($urandom(44553));
        pixel_in = PIX_W'($urandom);
        cycles(2);
        rst = 1'b0;
        run = 1'b1;
        check_frame(1'b0);
        check_frame(1'b0);
        stereo_en = 1'b1;
        check_frame(1'b0);
        check_frame(1'b1);
        check_frame(1'b1);
        stereo_en = 1'b0;
        run = 1'b0;
        cycles(4000);
        exp_q.delete();
        dev.got.delete();
        n = frames;
        cycles(3000);
        check(frames - n, 0);
        check(dev.got.size(), 0);
        reset_req = 1'b1;
        cycles(1);
        reset_req = 1'b0;
        check(32'(reset_n_in), 32'h0);
        n = 0;
        while (reset_n_in === 1'b0 && n < 400) begin
            cycles(1);
            n++;
        end
        check(n, RESET_LOW_CYCLES);
        if (n == 400) finish_test();
        run = 1'b1;
        check_frame(1'b0);
        cycles(700);
        rst = 1'b1;
        cycles(2);
        rst = 1'b0;
        exp_q.delete();
        dev.got.delete();
        check_frame(1'b0);
        finish_test();
    end
endmodule
bind video_source video_source_checker #(
    .EYE_SETUP_CYC(EYE_SETUP_CYC), .EYE_HOLD_CYC(EYE_HOLD_CYC)
) chk (
    .core_clk(core_clk), .rst(rst), .frame_sync(frame_sync), .line_sync(line_sync),
    .pixel_valid_in(pixel_valid_in), .eye_select(eye_select), .reset_n_in(reset_n_in)
);
`default_nettype wire
